// [common/mwd_map.vh]
// constants for the motion wake detector: register fields, reset values, encodings
`ifndef MWD_MAP_VH
`define MWD_MAP_VH

// motion_threshold_reg: 8-bit magnitude, 1 mg per lsb, zero disables the mode
`define MWD_THR_W 8
`define MWD_THR_RST 8'h00
`define MWD_THR_OFF 8'h00

// wake_pin_blanking_reg fields
`define MWD_BLK_RST 8'h00
`define MWD_BLK_CNT_MSB 5
`define MWD_BLK_CNT_LSB 0
`define MWD_BLK_CNT_W 6
`define MWD_SEL_MSB 7
`define MWD_SEL_LSB 6

// pin-select encodings
`define MWD_SEL_A_LOW 2'b00
`define MWD_SEL_B_LOW 2'b01
`define MWD_SEL_B_HIGH_ALT 2'b10
`define MWD_SEL_B_HIGH 2'b11

// primary_status_reg layout
`define MWD_STAT_W 8
`define MWD_STAT_RST 8'h00
`define MWD_STAT_WAKE_BIT 2

// sample width in milli-g, two's complement
`define MWD_SMP_W 16

`endif

// [core/mwd_accel_cmp.v]
// per-sample magnitude compare of three accelerometer axes against a threshold
`default_nettype none
`include "mwd_map.vh"

module mwd_accel_cmp #(
    parameter SMP_W = `MWD_SMP_W,
    parameter THR_W = `MWD_THR_W
) (
    input wire signed [SMP_W-1:0] smp_x,
    input wire signed [SMP_W-1:0] smp_y,
    input wire signed [SMP_W-1:0] smp_z,
    input wire [THR_W-1:0] thr,
    output wire over
);

    // absolute value one bit wider so the most negative sample does not wrap
    function [SMP_W:0] mwd_abs;
        input signed [SMP_W-1:0] v;
        begin
            if (v[SMP_W-1]) begin
                mwd_abs = {1'b0, ~v} + {{SMP_W{1'b0}}, 1'b1};
            end else begin
                mwd_abs = {1'b0, v};
            end
        end
    endfunction

    wire [SMP_W:0] thr_ext;

    // threshold in mg, one mg per lsb, zero extended to the magnitude width
    assign thr_ext = {{(SMP_W + 1 - THR_W){1'b0}}, thr};

    // any single axis strictly above the threshold counts as motion
    assign over = (mwd_abs(smp_x) > thr_ext) ||
                  (mwd_abs(smp_y) > thr_ext) ||
                  (mwd_abs(smp_z) > thr_ext);

endmodule
`default_nettype wire

// [core/mwd_top.v]
// motion wake detector: settings, blanking, event flag and toggling wake line
`default_nettype none
`include "mwd_map.vh"

module mwd_top #(
    parameter SMP_W = `MWD_SMP_W,
    parameter THR_W = `MWD_THR_W
) (
    input wire mclk,
    input wire rst_b,
    input wire cmd_write_wake_setting,
    input wire [THR_W-1:0] wr_threshold,
    input wire [7:0] wr_pin_blanking,
    input wire mode_change,
    input wire status_rd,
    input wire smp_valid,
    input wire signed [SMP_W-1:0] smp_x,
    input wire signed [SMP_W-1:0] smp_y,
    input wire signed [SMP_W-1:0] smp_z,
    input wire irq_a_normal,
    input wire irq_b_normal,
    output reg irq_line_a_q,
    output reg irq_line_b_q,
    output reg [`MWD_STAT_W-1:0] primary_status_q,
    output reg [`MWD_STAT_W-1:0] status_rd_data_q,
    output reg [THR_W-1:0] motion_threshold_reg_q,
    output reg [7:0] wake_pin_blanking_reg_q,
    output reg motion_wake_active_q,
    output reg motion_wake_event_q
);

    // select field of a pin/blanking settings byte
    function [1:0] sel_field;
        input [7:0] pb;
        begin
            sel_field = pb[`MWD_SEL_MSB:`MWD_SEL_LSB];
        end
    endfunction

    // selected line is line b for every code except the line-a code
    function sel_is_b;
        input [1:0] sel;
        begin
            sel_is_b = (sel != `MWD_SEL_A_LOW);
        end
    endfunction

    // initial level: high for both upper codes, including the alternate one
    function sel_init;
        input [1:0] sel;
        begin
            sel_init = (sel == `MWD_SEL_B_HIGH) || (sel == `MWD_SEL_B_HIGH_ALT);
        end
    endfunction

    reg [`MWD_BLK_CNT_W-1:0] blank_left_q;
    reg [`MWD_BLK_CNT_W-1:0] blank_left_d;
    reg wake_line_q;
    reg wake_line_d;
    reg flag_d;
    reg active_d;
    reg [THR_W-1:0] thr_d;
    reg [7:0] blk_d;
    reg line_a_d;
    reg line_b_d;
    reg [`MWD_STAT_W-1:0] stat_d;

    wire over;
    wire [1:0] sel;
    wire [1:0] wr_sel;
    wire line_is_b;
    wire line_init;
    wire start;
    wire blanking;
    wire hit;

    // one comparator over all three axes
    mwd_accel_cmp #(
        .SMP_W(SMP_W),
        .THR_W(THR_W)
    ) u_cmp (
        .smp_x(smp_x),
        .smp_y(smp_y),
        .smp_z(smp_z),
        .thr(motion_threshold_reg_q),
        .over(over)
    );

    // decode of the stored select field
    assign sel = sel_field(wake_pin_blanking_reg_q);
    assign line_is_b = sel_is_b(sel);
    assign line_init = sel_init(sel);

    // select field arriving with a settings command, used in the load cycle
    assign wr_sel = sel_field(wr_pin_blanking);

    // a settings command with a nonzero threshold (re)starts the mode
    assign start = cmd_write_wake_setting && (wr_threshold != `MWD_THR_OFF);

    // samples are discarded while the blanking count is still running
    assign blanking = (blank_left_q != {`MWD_BLK_CNT_W{1'b0}});

    // a qualified motion hit, only while the mode is running
    // any settings command, even one that ends the mode, blocks a same-cycle hit
    assign hit = motion_wake_active_q && !cmd_write_wake_setting &&
                 smp_valid && !blanking && over;

    // settings registers: loaded only by the write-wake-setting command
    always @* begin
        thr_d = motion_threshold_reg_q;
        blk_d = wake_pin_blanking_reg_q;
        if (cmd_write_wake_setting) begin
            thr_d = wr_threshold;
            blk_d = wr_pin_blanking;
        end
    end

    // mode state: entered on nonzero threshold, left on zero or a mode change
    always @* begin
        active_d = motion_wake_active_q;
        if (cmd_write_wake_setting) begin
            active_d = start;
        end else if (mode_change) begin
            active_d = 1'b0;
        end
    end

    // blanking counter: loaded on start, counts down one per valid (discarded) sample while nonzero
    always @* begin
        blank_left_d = blank_left_q;
        if (start) begin
            blank_left_d = wr_pin_blanking[`MWD_BLK_CNT_MSB:`MWD_BLK_CNT_LSB];
        end else if (!motion_wake_active_q) begin
            blank_left_d = {`MWD_BLK_CNT_W{1'b0}};
        end else if (smp_valid && blanking) begin
            blank_left_d = blank_left_q - {{(`MWD_BLK_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // wake line level and flag; a hit beats a same-cycle status read
    always @* begin
        wake_line_d = wake_line_q;
        flag_d = primary_status_q[`MWD_STAT_WAKE_BIT];
        if (start) begin
            wake_line_d = sel_init(wr_sel);
            flag_d = 1'b0;
        end else if (hit) begin
            wake_line_d = status_rd ? ~line_init : ~wake_line_q;
            flag_d = 1'b1;
        end else if (status_rd) begin
            wake_line_d = line_init;
            flag_d = 1'b0;
        end
    end

    // pin muxing: the selected line carries the wake level, the other its normal use
    // the unselected line never carries wake levels, so its host wiring is untouched
    always @* begin
        line_a_d = irq_a_normal;
        line_b_d = irq_b_normal;
        if (active_d) begin
            if (start ? sel_is_b(wr_sel) : line_is_b) begin
                line_b_d = wake_line_d;
            end else begin
                line_a_d = wake_line_d;
            end
        end
    end

    // status word: only the wake flag is implemented, other bits read zero
    always @* begin
        stat_d = `MWD_STAT_RST;
        stat_d[`MWD_STAT_WAKE_BIT] = flag_d;
    end

    // state registers
    always @(posedge mclk) begin
        if (!rst_b) begin
            motion_threshold_reg_q <= `MWD_THR_RST;
            wake_pin_blanking_reg_q <= `MWD_BLK_RST;
            motion_wake_active_q <= 1'b0;
            blank_left_q <= {`MWD_BLK_CNT_W{1'b0}};
            wake_line_q <= 1'b0;
            primary_status_q <= `MWD_STAT_RST;
        end else begin
            motion_threshold_reg_q <= thr_d;
            wake_pin_blanking_reg_q <= blk_d;
            motion_wake_active_q <= active_d;
            blank_left_q <= blank_left_d;
            wake_line_q <= wake_line_d;
            primary_status_q <= stat_d;
        end
    end

    // pin and read-data outputs, all registered
    always @(posedge mclk) begin
        if (!rst_b) begin
            irq_line_a_q <= 1'b0;
            irq_line_b_q <= 1'b0;
            status_rd_data_q <= `MWD_STAT_RST;
            motion_wake_event_q <= 1'b0;
        end else begin
            irq_line_a_q <= line_a_d;
            irq_line_b_q <= line_b_d;
            motion_wake_event_q <= hit; // one-cycle pulse per event
            if (status_rd) begin
                status_rd_data_q <= primary_status_q; // value before the clear
            end
        end
    end

endmodule
`default_nettype wire

// [sim/mwd_checker.sv]
// assertion checker for the motion wake detector ports
`default_nettype none
module mwd_checker #(parameter THR_W = 8) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cmd_write_wake_setting,
    input wire logic [THR_W-1:0] wr_threshold,
    input wire logic [7:0] wr_pin_blanking,
    input wire logic mode_change,
    input wire logic status_rd,
    input wire logic smp_valid,
    input wire logic irq_line_a_q,
    input wire logic irq_line_b_q,
    input wire logic [7:0] primary_status_q,
    input wire logic [7:0] status_rd_data_q,
    input wire logic [THR_W-1:0] motion_threshold_reg_q,
    input wire logic [7:0] wake_pin_blanking_reg_q,
    input wire logic motion_wake_active_q,
    input wire logic motion_wake_event_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // selected line, its initial level, wake flag and short aliases
    wire cmd = cmd_write_wake_setting;
    wire init = wake_pin_blanking_reg_q[7];
    wire line = (wake_pin_blanking_reg_q[7:6] == 2'b00) ? irq_line_a_q : irq_line_b_q;
    wire flag = primary_status_q[2];
    wire evt = motion_wake_event_q;
    wire act = motion_wake_active_q;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_evt_flag: assert property (evt |-> flag)
        else $error("event without wake flag");
    a_evt_cause: assert property (evt |-> $past(smp_valid && act))
        else $error("event without an active sample");
    a_evt_toggle: assert property (evt && !$past(status_rd) |-> line != $past(line))
        else $error("event did not invert the line");
    a_rd_data: assert property (status_rd |=> status_rd_data_q == $past(primary_status_q))
        else $error("read data differs from status");
    a_rd_clear: assert property (status_rd && !cmd && !mode_change && act ##1 !evt
        |-> !flag && line == init) else $error("read did not clear flag and line");
    a_cmd_load: assert property (cmd |=> act == ($past(wr_threshold) != 0)
        && motion_threshold_reg_q == $past(wr_threshold)
        && wake_pin_blanking_reg_q == $past(wr_pin_blanking)) else $error("settings not loaded");
    a_cmd_clear: assert property (cmd && wr_threshold != 0 |=> !flag && line == init)
        else $error("nonzero threshold did not clear");
    a_mode_hold: assert property (act && !cmd |=> act == !$past(mode_change))
        else $error("wake mode left without mode change");
endmodule
bind mwd_top mwd_checker #(.THR_W(THR_W)) chk_u (.*);
`default_nettype wire

// [sim/mwd_host.sv]
// host processor model: settings command, status read and mode change
`default_nettype none
module mwd_host (
    input wire logic mclk,
    output logic cmd_write_wake_setting,
    output logic [7:0] wr_threshold,
    output logic [7:0] wr_pin_blanking,
    output logic mode_change,
    output logic status_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle host at time zero
    initial begin
        {cmd_write_wake_setting, mode_change, status_rd} = 3'h0;
        {wr_threshold, wr_pin_blanking} = 16'h0000;
    end
    // one-cycle settings command; data inverted once released
    task setup(input logic [7:0] t, input logic [7:0] k);
        @(posedge mclk);
        cmd_write_wake_setting <= 1;
        wr_threshold <= t;
        wr_pin_blanking <= k;
        @(posedge mclk);
        cmd_write_wake_setting <= 0;
        wr_threshold <= ~t;
        wr_pin_blanking <= ~k;
        #1;
    endtask
    // status read after a wake interrupt
    task rd();
        @(posedge mclk);
        status_rd <= 1;
        @(posedge mclk);
        status_rd <= 0;
        #1;
    endtask
    // command another operating mode
    task leave();
        @(posedge mclk);
        mode_change <= 1;
        @(posedge mclk);
        mode_change <= 0;
        #1;
    endtask
endmodule
`default_nettype wire

// [sim/mwd_tb_top.sv]
// self-checking bench for the motion wake detector
`default_nettype none
module mwd_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b = 0, smp_valid = 0, irq_a_normal = 0, irq_b_normal = 1;
    logic signed [15:0] smp_x = 0, smp_y = 0, smp_z = 0;
    logic cmd_write_wake_setting, mode_change, status_rd, irq_line_a_q, irq_line_b_q;
    logic motion_wake_active_q, motion_wake_event_q;
    logic [7:0] wr_threshold, wr_pin_blanking, primary_status_q, status_rd_data_q;
    logic [7:0] motion_threshold_reg_q, wake_pin_blanking_reg_q;
    int fails = 0;
    int n_tests = 0;
    mwd_top dut_u (.*);
    mwd_host host_u (.*);
    initial forever #2 mclk = ~mclk;
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // one sample in mg at the host's chosen rate, answer one edge later
    task smp(input logic signed [15:0] x, y, z);
        @(posedge mclk);
        smp_valid <= 1;
        smp_x <= x;
        smp_y <= y;
        smp_z <= z;
        @(posedge mclk);
        smp_valid <= 0;
        #1;
    endtask
    task t_blank();
        host_u.setup(8'h20, 8'hc3);
        chk("threshold", 8'h20, motion_threshold_reg_q);
        chk("line b init", 1, irq_line_b_q);
        chk("blanking reg", 8'hc3, wake_pin_blanking_reg_q);
        repeat (3) smp(16'sh0100, 0, 0);
        chk("blanked", 8'h00, primary_status_q);
        smp(16'sh0020, 0, 0);
        chk("equal", 0, motion_wake_event_q);
        smp(0, 0, -16'sh0021);
        chk("event", 1, motion_wake_event_q);
        chk("flag", 8'h04, primary_status_q);
        chk("toggle", 0, irq_line_b_q);
        $display("blanking test done");
    endtask
    task t_read();
        host_u.rd();
        chk("read data", 8'h04, status_rd_data_q);
        chk("cleared", 8'h00, primary_status_q);
        chk("restored", 1, irq_line_b_q);
        smp(0, 16'sh7fff, 0);
        smp(0, 16'sh7fff, 0);
        chk("two toggles", 1, irq_line_b_q);
        fork
            host_u.rd();
            smp(0, 16'sh7fff, 0);
        join
        chk("set wins flag", 8'h04, primary_status_q);
        chk("set wins line", 0, irq_line_b_q);
        chk("race read data", 8'h04, status_rd_data_q);
        chk("race event", 1, motion_wake_event_q);
        $display("read test done");
    endtask
    task t_sel();
        logic [1:0] s;
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            host_u.setup(8'h10, {s, 6'h00});
            chk("flag cleared", 8'h00, primary_status_q);
            chk("init", s[1], s == 0 ? irq_line_a_q : irq_line_b_q);
            smp(16'sh0011, 0, 0);
            chk("inverted", !s[1], s == 0 ? irq_line_a_q : irq_line_b_q);
        end
        $display("select test done");
    endtask
    task t_idle();
        host_u.setup(8'h00, 8'h00);
        chk("disabled", 0, motion_wake_active_q);
        @(posedge mclk);
        irq_a_normal <= 1;
        irq_b_normal <= 0;
        repeat (2) @(posedge mclk);
        #1;
        chk("normal pins", 8'h01, {irq_line_b_q, irq_line_a_q});
        host_u.setup(8'h10, 8'h40);
        host_u.leave();
        chk("mode left", 0, motion_wake_active_q);
        smp(16'sh0100, 0, 0);
        chk("no event", 0, motion_wake_event_q);
        $display("idle test done");
    endtask
    task give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1;
        t_blank();
        t_read();
        t_sel();
        t_idle();
        give_verdict();
    end
endmodule
`default_nettype wire
